//--- logic/tbr_top.sv
// The strobed register port and the address map were left to the implementer.
`timescale 1ns/1ns
`include "tbr_defs.svh"
module tbr_top (
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                reset_n,
  // Register port
  input  wire logic [`TBR_AW-1:0]  reg_addr,
  input  wire logic [`TBR_DW-1:0]  reg_wdata,
  input  wire logic                reg_wr,
  input  wire logic                reg_rd,
  output logic      [`TBR_DW-1:0]  reg_rdata,
  // Backplane pins
  input  wire logic                tx_bp_clock,
  input  wire logic                tx_bp_frame_pulse_in,
  output logic                     tx_bp_frame_pulse_out,
  output logic                     tx_bp_frame_pulse_oe,
  input  wire logic                tx_bp_voice_data,
  input  wire logic                tx_bp_signaling,
  // Received channel stream
  output logic      [7:0]          chan_data,
  output logic                     chan_sig,
  output tbr_pkg::tbr_chan_t       chan_num,
  output logic                     chan_strobe,
  output logic                     fbit,
  output logic                     fbit_strobe
);

  ////////////////////////////////////////////////////////////////////////////
  // Configuration
  tbr_pkg::tbr_rate_e rate;
  logic               rate_locked;
  logic               e1_select;
  logic               clock_double_sel;
  logic               frame_edge_sel;
  logic               data_edge_sel;
  logic               pulse_direction;
  logic               chan_pack;
  logic [6:0]         timeslot_shift;
  logic               bit_shift_on;
  logic [2:0]         bit_shift;
  localparam logic [7:0] cfg_in = `TBR_CFG_RST;

  // The configuration reset branch loads this constant only, never live logic

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rate        <= tbr_pkg::tbr_rate_e'(2'b00);
      rate_locked <= 1'b0;
    end else if (reg_wr && reg_addr == `TBR_REG_CFG && !rate_locked) begin
      // Speed fixed until the next reset
      rate        <= tbr_pkg::tbr_rate_e'(reg_wdata[`TBR_CFG_RATE]);
      rate_locked <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      e1_select        <= cfg_in[`TBR_CFG_E1];
      clock_double_sel <= cfg_in[`TBR_CFG_CDS];
      frame_edge_sel   <= cfg_in[`TBR_CFG_FE];
      data_edge_sel    <= cfg_in[`TBR_CFG_DE];
      pulse_direction  <= cfg_in[`TBR_CFG_DIR];
      chan_pack        <= cfg_in[`TBR_CFG_PACK];
    end else if (reg_wr && reg_addr == `TBR_REG_CFG) begin
      e1_select        <= reg_wdata[`TBR_CFG_E1];
      clock_double_sel <= reg_wdata[`TBR_CFG_CDS];
      frame_edge_sel   <= reg_wdata[`TBR_CFG_FE];
      data_edge_sel    <= reg_wdata[`TBR_CFG_DE];
      pulse_direction  <= reg_wdata[`TBR_CFG_DIR];
      chan_pack        <= reg_wdata[`TBR_CFG_PACK];
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      timeslot_shift <= `TBR_SLOT_RST;
      bit_shift_on   <= 1'b0;
      bit_shift      <= 3'h0;
    end else if (reg_wr && reg_addr == `TBR_REG_SLOT) begin
      timeslot_shift <= reg_wdata[6:0];
    end else if (reg_wr && reg_addr == `TBR_REG_BIT) begin
      bit_shift_on   <= reg_wdata[`TBR_BIT_ON];
      bit_shift      <= reg_wdata[`TBR_BIT_SHIFT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Link sampling
  logic clk_rise;
  logic clk_fall;
  logic fp_s;
  logic voice_s;
  logic sig_s;

  tbr_link_sync u_sync (
    .clk        (clk),
    .reset_n    (reset_n),
    .link_clk   (tx_bp_clock),
    .link_fp    (tx_bp_frame_pulse_in),
    .link_voice (tx_bp_voice_data),
    .link_sig   (tx_bp_signaling),
    .clk_rise   (clk_rise),
    .clk_fall   (clk_fall),
    .fp_s       (fp_s),
    .voice_s    (voice_s),
    .sig_s      (sig_s)
  );

  logic data_edge;
  logic frame_edge;
  logic edges_equal;
  logic phase;
  logic tick;

  assign data_edge   = data_edge_sel ? clk_rise : clk_fall;
  assign frame_edge  = frame_edge_sel ? clk_rise : clk_fall;
  assign edges_equal = (frame_edge_sel == data_edge_sel);
  // Doubled clock: only every other data edge carries a bit
  assign tick = data_edge && !(clock_double_sel && phase);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) phase <= 1'b0;
    else if (data_edge) phase <= clock_double_sel ? ~phase : 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Frame position
  function automatic tbr_pkg::tbr_pos_t wrap_inc(tbr_pkg::tbr_pos_t p, logic [10:0] len);
    logic [10:0] n;
    n = {1'b0, p} + 11'd1;
    wrap_inc = (n >= len) ? 10'h000 : n[9:0];
  endfunction

  logic [10:0]       frame_len;
  logic [10:0]       shift_bits;
  logic [10:0]       shift_mod;
  tbr_pkg::tbr_pos_t start_pos;
  tbr_pkg::tbr_pos_t last_pos;
  tbr_pkg::tbr_pos_t pos;
  tbr_pkg::tbr_pos_t cur_pos;
  logic              fp_hold;
  logic              fp_now;

  always_comb begin
    unique case (rate)
      tbr_pkg::TBR_RATE_1544: frame_len = `TBR_LEN_1544;
      tbr_pkg::TBR_RATE_2048: frame_len = `TBR_LEN_2048;
      tbr_pkg::TBR_RATE_4096: frame_len = `TBR_LEN_4096;
      tbr_pkg::TBR_RATE_8192: frame_len = `TBR_LEN_8192;
    endcase
  end

  // Zero shifts put the pulse on the frame's first bit
  assign shift_bits = {1'b0, timeslot_shift, 3'b000} + {8'h00, bit_shift_on ? bit_shift : 3'h0};
  assign shift_mod  = shift_bits % frame_len;
  assign start_pos  = (shift_mod == 11'd0) ? 10'h000 : 10'(frame_len - shift_mod);
  assign last_pos   = 10'(frame_len - 11'd1);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) fp_hold <= 1'b0;
    else if (frame_edge) fp_hold <= fp_s;
  end

  // Equal selects: pulse sampled with the data; otherwise one edge earlier
  assign fp_now  = pulse_direction && (edges_equal ? fp_s : fp_hold);
  assign cur_pos = fp_now ? start_pos : pos;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) pos <= 10'h000;
    else if (tick) pos <= wrap_inc(cur_pos, frame_len);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output frame pulse
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_bp_frame_pulse_out <= 1'b0;
    end else if (frame_edge) begin
      // Unequal selects lead position 0, not the shifted start, by three link edges
      tx_bp_frame_pulse_out <= edges_equal ? (pos == start_pos)
                                           : (pos == last_pos);
    end
  end

  assign tx_bp_frame_pulse_oe = ~pulse_direction;

  ////////////////////////////////////////////////////////////////////////////
  // Byte assembly
  logic               is_fbit;
  logic               chan_ok;
  tbr_pkg::tbr_chan_t map_chan;
  logic [2:0]         bit_idx;
  logic [7:0]         shreg;

  tbr_slot_map u_map (
    .rate      (rate),
    .e1_select (e1_select),
    .chan_pack (chan_pack),
    .pos       (cur_pos),
    .is_fbit   (is_fbit),
    .chan_ok   (chan_ok),
    .chan      (map_chan),
    .bit_idx   (bit_idx)
  );

  // Bit 0 arrives first and lands in the MSB
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) shreg <= 8'h00;
    else if (tick && chan_ok) shreg <= {shreg[6:0], voice_s};
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      chan_data   <= 8'h00;
      chan_sig    <= 1'b0;
      chan_num    <= 5'h00;
      chan_strobe <= 1'b0;
    end else begin
      chan_strobe <= tick && chan_ok && bit_idx == 3'd7;
      if (tick && chan_ok && bit_idx == 3'd7) begin
        chan_data <= {shreg[6:0], voice_s};
        chan_sig  <= sig_s;
        chan_num  <= map_chan;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      fbit        <= 1'b0;
      fbit_strobe <= 1'b0;
    end else begin
      fbit_strobe <= tick && is_fbit && !e1_select;
      if (tick && is_fbit && !e1_select) fbit <= voice_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register read, answer in the following cycle
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      unique case (reg_addr)
        `TBR_REG_CFG:  reg_rdata <= {chan_pack, pulse_direction, data_edge_sel, frame_edge_sel,
                                     clock_double_sel, e1_select, rate};
        `TBR_REG_SLOT: reg_rdata <= {1'b0, timeslot_shift};
        `TBR_REG_BIT:  reg_rdata <= {4'h0, bit_shift, bit_shift_on};
        `TBR_REG_STAT: reg_rdata <= {fbit, pos[9:4], rate_locked};
        `TBR_REG_BYTE: reg_rdata <= chan_data;
        `TBR_REG_CHAN: reg_rdata <= {2'b00, chan_sig, chan_num};
        default:       reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);

  fp_in_same_a: assert property (tick && pulse_direction && edges_equal && fp_s
    |=> pos == wrap_inc($past(start_pos), $past(frame_len)))
    else $error("equal-edge frame pulse did not restart the frame");

  fp_in_early_a: assert property (tick && pulse_direction && !edges_equal && fp_hold
    |=> pos == wrap_inc($past(start_pos), $past(frame_len)))
    else $error("early frame pulse did not restart the frame");

  fp_out_same_a: assert property (frame_edge && !pulse_direction && edges_equal
    && pos == start_pos |=> tx_bp_frame_pulse_out)
    else $error("output pulse missing at frame start");

  fp_out_lead_a: assert property (frame_edge && !pulse_direction && !edges_equal
    && pos != last_pos |=> !tx_bp_frame_pulse_out)
    else $error("output pulse outside the lead position");

  edge_pick_a: assert property (tick |-> u_sync.stable[0] == data_edge_sel
    && $past(u_sync.stable[0]) != data_edge_sel)
    else $error("data sampled on the wrong link edge");

  rate_hold_a: assert property (rate_locked |=> $stable(rate) && rate_locked)
    else $error("line speed changed without reset");

  double_rate_a: assert property (clock_double_sel && tick |=> !tick[*5])
    else $error("doubled clock took two bits too close");

  pos_bound_a: assert property ({1'b0, pos} < frame_len)
    else $error("frame position beyond frame length");

  unused_slot_a: assert property (rate == tbr_pkg::TBR_RATE_2048 && !e1_select
    && !chan_pack && cur_pos[4:3] == 2'b00 |-> !chan_ok)
    else $error("T1 channel placed in an unused slot");

  byte_done_a: assert property (chan_strobe |-> $past(bit_idx) == 3'd7 && $past(tick))
    else $error("channel byte ended before bit 7");

  fbit_only_t1_a: assert property (fbit_strobe |-> !$past(e1_select))
    else $error("framing bit taken in E1 mode");

  byte_seen_c: cover property (chan_strobe && chan_num == 5'd23);
  fbit_seen_c: cover property (fbit_strobe && chan_pack);
  pulse_out_c: cover property (!pulse_direction && $rose(tx_bp_frame_pulse_out));
  fast_rate_c: cover property (rate == tbr_pkg::TBR_RATE_8192 && chan_strobe);
endmodule

//--- shared/tbr_defs.svh
`ifndef TBR_DEFS_SVH
`define TBR_DEFS_SVH

`define TBR_AW 4
`define TBR_DW 8

`define TBR_REG_CFG   4'h0
`define TBR_REG_SLOT  4'h1
`define TBR_REG_BIT   4'h2
`define TBR_REG_STAT  4'h3
`define TBR_REG_BYTE  4'h4
`define TBR_REG_CHAN  4'h5

`define TBR_CFG_RATE  1:0
`define TBR_CFG_E1    2
`define TBR_CFG_CDS   3
`define TBR_CFG_FE    4
`define TBR_CFG_DE    5
`define TBR_CFG_DIR   6
`define TBR_CFG_PACK  7
`define TBR_BIT_ON    0
`define TBR_BIT_SHIFT 3:1

`define TBR_CFG_RST   8'h00
`define TBR_SLOT_RST  7'h00
`define TBR_BIT_RST   4'h0

`define TBR_LEN_1544  11'd193
`define TBR_LEN_2048  11'd256
`define TBR_LEN_4096  11'd512
`define TBR_LEN_8192  11'd1024

`endif

//--- shared/tbr_pkg.sv
package tbr_pkg;
  typedef enum logic [1:0] {
    TBR_RATE_1544 = 2'b00,
    TBR_RATE_2048 = 2'b01,
    TBR_RATE_4096 = 2'b10,
    TBR_RATE_8192 = 2'b11
  } tbr_rate_e;
  typedef logic [9:0] tbr_pos_t;
  typedef logic [4:0] tbr_chan_t;
endpackage

//--- logic/tbr_link_sync.sv
`timescale 1ns/1ns
module tbr_link_sync (
  // Clock and reset
  input  wire logic clk,
  input  wire logic reset_n,
  // Raw link pins
  input  wire logic link_clk,
  input  wire logic link_fp,
  input  wire logic link_voice,
  input  wire logic link_sig,
  // Synchronised view
  output logic      clk_rise,
  output logic      clk_fall,
  output logic      fp_s,
  output logic      voice_s,
  output logic      sig_s
);
  logic [3:0] meta;
  logic [3:0] stable;
  logic       clk_last;

  // First stage feeds only the second
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      meta   <= 4'h0;
      stable <= 4'h0;
    end else begin
      meta   <= {link_sig, link_voice, link_fp, link_clk};
      stable <= meta;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) clk_last <= 1'b0;
    else clk_last <= stable[0];
  end

  assign clk_rise = stable[0] & ~clk_last;
  assign clk_fall = ~stable[0] & clk_last;
  assign fp_s     = stable[1];
  assign voice_s  = stable[2];
  assign sig_s    = stable[3];
endmodule

//--- logic/tbr_slot_map.sv
`timescale 1ns/1ns
module tbr_slot_map (
  // Format
  input  wire tbr_pkg::tbr_rate_e rate,
  input  wire logic               e1_select,
  input  wire logic               chan_pack,
  // Frame position
  input  wire tbr_pkg::tbr_pos_t  pos,
  // Placement
  output logic                    is_fbit,
  output logic                    chan_ok,
  output tbr_pkg::tbr_chan_t      chan,
  output logic [2:0]              bit_idx
);
  logic [6:0] phys;
  logic [4:0] lslot;
  logic       ilv_ok;
  logic [9:0] t1_pos;

  always_comb begin
    phys    = pos[9:3];
    t1_pos  = pos - 10'h001;
    lslot   = phys[4:0];
    ilv_ok  = 1'b1;
    is_fbit = 1'b0;
    chan_ok = 1'b0;
    chan    = 5'h00;
    bit_idx = pos[2:0];
    unique case (rate)
      tbr_pkg::TBR_RATE_1544: lslot = phys[4:0];
      tbr_pkg::TBR_RATE_2048: lslot = phys[4:0];
      tbr_pkg::TBR_RATE_4096: begin
        lslot  = phys[5:1];
        ilv_ok = ~phys[0];
      end
      tbr_pkg::TBR_RATE_8192: begin
        lslot  = phys[6:2];
        ilv_ok = (phys[1:0] == 2'b00);
      end
    endcase
    if (rate == tbr_pkg::TBR_RATE_1544) begin
      // F bit then 24 channels, no slot padding
      if (pos == 10'h000) begin
        is_fbit = 1'b1;
      end else begin
        chan_ok = 1'b1;
        chan    = t1_pos[7:3];
        bit_idx = t1_pos[2:0];
      end
    end else if (ilv_ok) begin
      if (e1_select) begin
        chan_ok = 1'b1;
        chan    = lslot;
      end else if (chan_pack) begin
        chan_ok = (lslot < 5'd24);
        chan    = lslot;
        is_fbit = (lslot == 5'd31) && (pos[2:0] == 3'd7);
      end else if (lslot[1:0] == 2'b00) begin
        is_fbit = (lslot == 5'd0) && (pos[2:0] == 3'd0);
      end else begin
        chan_ok = 1'b1;
        chan    = lslot - {2'b00, lslot[4:2]} - 5'd1;
      end
    end
  end
endmodule

//--- tb/tbr_far_end.sv
`timescale 1ns/1ns
module tbr_far_end (
  // Control from the bench
  input  wire logic        run,
  input  wire logic        fe,
  input  wire logic        de,
  input  wire logic        fp_drive,
  input  wire logic [31:0] pattern,
  input  var  int          len,
  // Link pins
  output logic             link_clk,
  output logic             fp,
  output logic             voice,
  output logic             sig,
  // Position of the bit now on the wire
  output int               pos
);
  int frm;

  initial begin
    link_clk = 1'b0;
    fp = 1'b0;
    voice = 1'b0;
    sig = 1'b0;
    pos = 0;
    frm = 0;
    forever begin
      wait (run);
      // Off the system clock grid, so sync flops never see a tie
      #13;
      pos = len - 2;
      while (run) begin
        link_clk = ~de;
        voice = pattern[(pos * 5 + frm) % 32];
        sig = pattern[(pos * 3 + 1) % 32];
        if (fe == de) fp = fp_drive && (pos == 0);
        #200;
        link_clk = de;
        if (fe != de) fp = fp_drive && (pos == len - 1);
        #200;
        pos = (pos + 1) % len;
        if (pos == 0) frm++;
      end
      // Released lines must not hold their last value
      voice = ~voice;
      sig = ~sig;
      fp = 1'b0;
    end
  end
endmodule

//--- tb/tb.sv
`timescale 1ns/1ns
`include "tbr_defs.svh"
module tb;
  logic                 clk = 1'b0;
  logic                 reset_n = 1'b0;
  logic [`TBR_AW-1:0]   reg_addr = '0;
  logic [`TBR_DW-1:0]   reg_wdata = '0;
  logic                 reg_wr = 1'b0;
  logic                 reg_rd = 1'b0;
  logic [`TBR_DW-1:0]   reg_rdata;
  logic                 link_clk, p_fp, p_voice, p_sig, fp_line, fp_out, fp_oe;
  logic [7:0]           chan_data, shreg = '0;
  logic                 chan_sig, chan_strobe, fbit, fbit_strobe;
  tbr_pkg::tbr_chan_t   chan_num;
  logic                 run = 1'b0, fe_s = 1'b0, de_s = 1'b0, fpd = 1'b0, model_on = 1'b0, armed = 1'b0;
  logic [31:0]          pattern = '0;
  int                   flen = 256, p_pos, rate, e1, pack, k, n_bits, errors = 0, n_tests = 0, cyc = 0;
  logic [13:0]          exp_q[$], e;
  logic                 fb_q[$];
  time                  t0;

  always #25 clk = ~clk;

  // Wire level of the shared frame pulse pin
  assign fp_line = fp_oe ? fp_out : p_fp;

  tbr_top u_tbr_top (
    .clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tx_bp_clock(link_clk), .tx_bp_frame_pulse_in(fp_line),
    .tx_bp_frame_pulse_out(fp_out), .tx_bp_frame_pulse_oe(fp_oe), .tx_bp_voice_data(p_voice),
    .tx_bp_signaling(p_sig), .chan_data(chan_data), .chan_sig(chan_sig), .chan_num(chan_num),
    .chan_strobe(chan_strobe), .fbit(fbit), .fbit_strobe(fbit_strobe)
  );

  tbr_far_end u_tbr_far_end (
    .run(run), .fe(fe_s), .de(de_s), .fp_drive(fpd), .pattern(pattern), .len(flen),
    .link_clk(link_clk), .fp(p_fp), .voice(p_voice), .sig(p_sig), .pos(p_pos)
  );

  ////////////////////////////////////////////////////////////////
  // Reference placement: -2 framing bit, -1 nothing, else channel
  function automatic int kind(int p, int r, int e, int pk);
    int ls, b;
    if (r == 0) return (p == 0) ? -2 : (((p - 1) % 8 == 7) ? (p - 1) / 8 : -1);
    b = p % 8;
    ls = p / 8;
    if (ls % (1 << (r - 1)) != 0) return -1;
    ls = ls / (1 << (r - 1));
    if (e == 1) return (b == 7) ? ls : -1;
    if (pk == 0) return (ls == 0 && b == 0) ? -2 : ((b == 7 && ls % 4 != 0) ? ls - ls / 4 - 1 : -1);
    return (ls == 31 && b == 7) ? -2 : ((b == 7 && ls < 24) ? ls : -1);
  endfunction

  always @(link_clk) begin
    if (model_on && link_clk === de_s) begin
      shreg = {shreg[6:0], p_voice};
      k = kind(p_pos, rate, e1, pack);
      if (p_pos == 0) armed = 1'b1;
      if (armed) begin
        n_bits++;
        if (k == -2) fb_q.push_back(p_voice);
        else if (k >= 0) exp_q.push_back({k[4:0], p_sig, shreg});
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  task automatic stop_test();
    if (errors == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic check(logic [13:0] g, logic [13:0] x, string m);
    n_tests++;
    if (g !== x) begin
      errors++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask

  // Outputs looked at mid-cycle, where they have settled
  always @(negedge clk) begin
    cyc++;
    if (cyc == 90000) begin
      errors++;
      $display("CHECK FAILED %0t timeout", $time);
      stop_test();
    end
    if (armed && chan_strobe === 1'b1) begin
      e = (exp_q.size() > 0) ? exp_q.pop_front() : 'x;
      check({chan_num, chan_sig, chan_data}, e, "channel byte");
    end
    if (armed && fbit_strobe === 1'b1) begin
      e = (fb_q.size() > 0) ? {13'h0, fb_q.pop_front()} : 'x;
      check({13'h0, fbit}, e, "framing bit");
    end
  end

  task automatic reg_write(logic [3:0] a, logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic reg_read(logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    d = reg_rdata;
  endtask

  // New line speed only after a reset, as software must do
  task automatic do_reset(logic [7:0] cfg);
    logic [7:0] got;
    @(posedge clk);
    reset_n <= 1'b0;
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    reg_read(`TBR_REG_CFG, got);
    check(got, `TBR_CFG_RST, "config reset value");
    check(fp_oe, 1'b1, "pulse pin driven after reset");
    reg_write(`TBR_REG_CFG, cfg);
    reg_write(`TBR_REG_CFG, cfg ^ 8'h01);
    reg_read(`TBR_REG_CFG, got);
    check(got, cfg, "line speed not held");
    reg_read(`TBR_REG_STAT, got);
    check(got[0], 1'b1, "speed lock flag");
  endtask

  task automatic run_case(int r, int e, int pk, logic f, logic d);
    do_reset({pk[0], 1'b1, d, f, 1'b0, e[0], r[1:0]});
    rate = r;
    e1 = e;
    pack = pk;
    fe_s <= f;
    de_s <= d;
    fpd <= 1'b1;
    flen = (r == 0) ? 193 : 256 << (r - 1);
    pattern <= $urandom;
    n_bits = 0;
    armed = 1'b0;
    model_on = 1'b1;
    run <= 1'b1;
    wait (n_bits >= 2 * flen);
    run <= 1'b0;
    model_on = 1'b0;
    repeat (40) @(posedge clk);
    check(14'(exp_q.size()), 14'd0, "channel bytes missing");
    check(14'(fb_q.size()), 14'd0, "framing bits missing");
    armed = 1'b0;
    exp_q.delete();
    fb_q.delete();
  endtask

  ////////////////////////////////////////////////////////////////
  initial begin
    logic [7:0] got;
    void'($urandom(32'hb5ab));
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    // Output pulse, E1 2.048: equal edges, then falling frame edge with rising data edge
    for (int i = 0; i < 2; i++) begin
      do_reset((i == 0) ? 8'h35 : 8'h25);
      reg_write(4'hf, 8'ha5);
      reg_read(4'hf, got);
      check(got, 8'h00, "unmapped read");
      check(fp_oe, 1'b1, "pulse pin driven");
      fe_s <= (i == 0);
      de_s <= 1'b1;
      fpd <= 1'b0;
      flen = 256;
      run <= 1'b1;
      @(posedge fp_out);
      t0 = $time;
      @(posedge fp_out);
      check(14'(($time - t0) / 50), 14'd2048, "pulse period");
      run <= 1'b0;
      repeat (20) @(posedge clk);
    end
    run_case(1, 1, 0, 1'b1, 1'b1);
    run_case(1, 0, 0, 1'b1, 1'b1);
    run_case(1, 0, 1, 1'b1, 1'b0);
    run_case(0, 0, 0, 1'b0, 1'b0);
    run_case(2, 1, 0, 1'b1, 1'b1);
    run_case(2, 0, 0, 1'b1, 1'b1);
    run_case(3, 1, 0, 1'b0, 1'b1);
    stop_test();
  end
endmodule
